// ---- src/buck_ctl_pkg.sv ----
package buck_ctl_pkg;

	// ====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MIN_OFF_NS    = 320;
	localparam int MIN_OFF_CYC   = (MIN_OFF_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int DEAD_NS       = 16;
	localparam int DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CL_CYCLES     = 256;

	// ====================================================================
	// register map
	localparam logic [3:0]  CTRL_OFFS       = 4'h0;
	localparam logic [3:0]  STATUS_OFFS     = 4'h4;
	localparam logic [3:0]  CLCNT_OFFS      = 4'h8;
	localparam int          CTRL_RUN_BIT    = 0;
	localparam logic        CTRL_RUN_RST    = 1'b1;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// ====================================================================
	// types
	typedef struct packed {
		logic pwm_trip;
		logic ilim_trip;
		logic ss_below_ref;
		logic switch_node_above_neg;
		logic restart_above_th;
		logic restart_grounded;
		logic sample_over_limit;
		logic line_uv_above_shdn;
		logic line_uv_above_th;
		logic bias_ok;
		logic ccm_select;
		logic ls_gate_low;
		logic hs_gate_low;
		logic osc_tick;
	} flags_s;

	typedef enum logic [3:0] {
		OP_OFF     = 4'h1,
		OP_RUN     = 4'h2,
		OP_HICCUP  = 4'h4,
		OP_LATCHED = 4'h8
	} op_e;

	typedef enum logic [6:0] {
		G_IDLE    = 7'h01,
		G_LS_FALL = 7'h02,
		G_HS_DLY  = 7'h04,
		G_HS_ON   = 7'h08,
		G_HS_FALL = 7'h10,
		G_LS_DLY  = 7'h20,
		G_LS_ON   = 7'h40
	} gate_e;

	typedef enum logic [2:0] {
		RM_HICCUP = 3'h1,
		RM_LATCH  = 3'h2,
		RM_NONE   = 3'h4
	} rmode_e;

endpackage

// ---- src/buck_pwm_sequencer.sv ----
// Functional notes
// - end cycle when ramp exceeds comp minus offset
// - regulate to lower of soft-start, reference
// - diode emulation: low side off above -5mV
// - force diode emulation while soft-start below reference
// - ramp over current limit ends cycle
// - skip pulses while sampled current over limit
// - 256 limited cycles enter standby, charge restart
// - standby holds gates off, discharges soft-start
// - restart threshold: discharge node, soft-start again
// - restart high at power-on: no hiccup
// - restart grounded: latch off until line shutdown
// - restart mode latched once at power-on
// - high side forced off 320ns each cycle
// - low side off and low before high on
// - high side low before low side on
// - line standby: gates off, soft-start held low
// - switch only with bias and line good
// - sample recirculating current before high-side on
//
// The register offsets and register access over AXI4-Lite were decided locally.
module buck_pwm_sequencer #(
	parameter int CL_COUNT   = buck_ctl_pkg::CL_CYCLES,
	parameter int MIN_OFF    = buck_ctl_pkg::MIN_OFF_CYC,
	parameter int DEAD       = buck_ctl_pkg::DEAD_CYC,
	parameter int AXI_AW     = 4
) (
	input  wire logic              aclk,                  // clock
	input  wire logic              aresetn,               // sync reset
	input  wire logic              clk_en,                // freeze when low
	input  wire logic              pwm_trip,              // ramp > comp-1.2V
	input  wire logic              ilim_trip,             // ramp > 1.2V
	input  wire logic              ss_below_ref,          // ss < 0.8V
	input  wire logic              switch_node_above_neg, // node > -5mV
	input  wire logic              restart_above_th,      // node > 1.25V
	input  wire logic              restart_grounded,      // node at ground
	input  wire logic              sample_over_limit,     // held current high
	input  wire logic              line_uv_above_shdn,    // line > 0.4V
	input  wire logic              line_uv_above_th,      // line > 1.25V
	input  wire logic              bias_ok,               // bias above lockout
	input  wire logic              diode_emulation_select, // pin > 3V
	input  wire logic              ls_gate_low,           // low gate fallen
	input  wire logic              hs_gate_low,           // high gate fallen
	input  wire logic              osc_tick,              // oscillator edge
	output logic                   high_side_gate,        // high switch
	output logic                   low_side_gate,         // low switch
	output logic                   ss_discharge,          // ss pull-down
	output logic                   ref_from_ss,           // ss is reference
	output logic                   restart_charge,        // 10uA source on
	output logic                   restart_discharge,     // node pull-down
	output logic                   sample_hold,           // sample strobe
	output logic                   diode_emulation,       // emulation active
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,          // write address
	input  wire logic              s_axi_awvalid,         // aw valid
	output logic                   s_axi_awready,         // aw ready
	input  wire logic [31:0]       s_axi_wdata,           // write data
	input  wire logic [3:0]        s_axi_wstrb,           // byte enables
	input  wire logic              s_axi_wvalid,          // w valid
	output logic                   s_axi_wready,          // w ready
	output logic [1:0]             s_axi_bresp,           // write response
	output logic                   s_axi_bvalid,          // b valid
	input  wire logic              s_axi_bready,          // b ready
	input  wire logic [AXI_AW-1:0] s_axi_araddr,          // read address
	input  wire logic              s_axi_arvalid,         // ar valid
	output logic                   s_axi_arready,         // ar ready
	output logic [31:0]            s_axi_rdata,           // read data
	output logic [1:0]             s_axi_rresp,           // read response
	output logic                   s_axi_rvalid,          // r valid
	input  wire logic              s_axi_rready           // r ready
);

	localparam int CW = $clog2(CL_COUNT + 1);
	localparam int OW = $clog2(MIN_OFF + 1);
	localparam int DW = $clog2(DEAD + 1);

	// ====================================================================
	// state
	typedef struct packed {
		buck_ctl_pkg::flags_s s1;
		buck_ctl_pkg::flags_s s2;
		logic                 tick_d;
		buck_ctl_pkg::op_e    op;
		buck_ctl_pkg::gate_e  gate;
		buck_ctl_pkg::rmode_e rmode;
		logic                 cfg_done;
		logic [CW-1:0]        cl_cnt;
		logic                 cl_seen;
		logic                 pend;
		logic [OW-1:0]        off_cnt;
		logic [DW-1:0]        dly;
		logic                 hs;
		logic                 ls;
		logic                 ss_dis;
		logic                 ref_ss;
		logic                 rst_chg;
		logic                 rst_dis;
		logic                 smp;
		logic                 de;
		logic                 run_en;
		logic                 aw_got;
		logic                 w_got;
		logic [AXI_AW-1:0]    waddr;
		logic                 wbit;
		logic                 wstb;
		logic                 awrdy;
		logic                 wrdy;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arrdy;
		logic                 rvalid;
		logic [1:0]           rresp;
		logic [31:0]          rdata;
	} state_s;

	state_s               st_ff;
	state_s               nxt_st;
	buck_ctl_pkg::flags_s fl_in;
	logic                 tick;
	logic                 de_now;
	logic                 run_ok;

	function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
		reg_hit = (a == AXI_AW'(buck_ctl_pkg::CTRL_OFFS))
			|| (a == AXI_AW'(buck_ctl_pkg::STATUS_OFFS))
			|| (a == AXI_AW'(buck_ctl_pkg::CLCNT_OFFS));
	endfunction

	// ====================================================================
	// comparator inputs
	assign fl_in = {pwm_trip, ilim_trip, ss_below_ref,
		switch_node_above_neg, restart_above_th, restart_grounded,
		sample_over_limit, line_uv_above_shdn, line_uv_above_th, bias_ok,
		diode_emulation_select, ls_gate_low, hs_gate_low, osc_tick};
	assign tick   = st_ff.s2.osc_tick & ~st_ff.tick_d;
	assign de_now = ~st_ff.s2.ccm_select | st_ff.s2.ss_below_ref;
	assign run_ok = st_ff.s2.bias_ok & st_ff.s2.line_uv_above_th
		& st_ff.run_en & st_ff.cfg_done;

	// ====================================================================
	// next state
	always_comb begin
		logic cl_evt;
		logic cl_any;
		cl_evt = 1'b0;
		cl_any = 1'b0;
		nxt_st = st_ff;
		nxt_st.s1      = fl_in;
		nxt_st.s2      = st_ff.s1;
		nxt_st.tick_d  = st_ff.s2.osc_tick;
		nxt_st.smp     = 1'b0;
		nxt_st.ref_ss  = st_ff.s2.ss_below_ref;
		nxt_st.de      = de_now;
		nxt_st.rst_dis = st_ff.rst_dis & st_ff.s2.restart_above_th;
		if (st_ff.off_cnt != '0) begin
			nxt_st.off_cnt = OW'(st_ff.off_cnt - 1'b1);
		end
		if (!st_ff.cfg_done && st_ff.s2.line_uv_above_th
			&& st_ff.s2.bias_ok) begin
			nxt_st.cfg_done = 1'b1;
			if (st_ff.s2.restart_above_th) begin
				nxt_st.rmode = buck_ctl_pkg::RM_NONE;
			end else if (st_ff.s2.restart_grounded) begin
				nxt_st.rmode = buck_ctl_pkg::RM_LATCH;
			end else begin
				nxt_st.rmode = buck_ctl_pkg::RM_HICCUP;
			end
		end

		case (st_ff.op)
		buck_ctl_pkg::OP_OFF: begin
			nxt_st.gate   = buck_ctl_pkg::G_IDLE;
			nxt_st.hs     = 1'b0;
			nxt_st.ls     = 1'b0;
			nxt_st.ss_dis = 1'b1;
			nxt_st.rst_chg = 1'b0;
			nxt_st.cl_cnt = '0;
			nxt_st.cl_seen = 1'b0;
			nxt_st.pend   = 1'b0;
			if (run_ok) begin
				nxt_st.op     = buck_ctl_pkg::OP_RUN;
				nxt_st.ss_dis = 1'b0;
			end
		end
		buck_ctl_pkg::OP_RUN: begin
			case (st_ff.gate)
			buck_ctl_pkg::G_IDLE,
			buck_ctl_pkg::G_LS_ON: begin
				if (st_ff.pend && st_ff.off_cnt == '0) begin
					nxt_st.pend = 1'b0;
					if (st_ff.s2.sample_over_limit) begin
						cl_evt = 1'b1;
					end else begin
						nxt_st.ls   = 1'b0;
						nxt_st.gate = buck_ctl_pkg::G_LS_FALL;
					end
				end else if (st_ff.gate == buck_ctl_pkg::G_LS_ON
					&& de_now && st_ff.s2.switch_node_above_neg) begin
					nxt_st.ls   = 1'b0;
					nxt_st.gate = buck_ctl_pkg::G_IDLE;
				end
			end
			buck_ctl_pkg::G_LS_FALL: begin
				if (st_ff.s2.ls_gate_low) begin
					nxt_st.dly  = DW'(DEAD - 1);
					nxt_st.gate = buck_ctl_pkg::G_HS_DLY;
				end
			end
			buck_ctl_pkg::G_HS_DLY: begin
				if (st_ff.dly == '0) begin
					nxt_st.hs   = 1'b1;
					nxt_st.gate = buck_ctl_pkg::G_HS_ON;
				end else begin
					nxt_st.dly = DW'(st_ff.dly - 1'b1);
				end
			end
			buck_ctl_pkg::G_HS_ON: begin
				if (st_ff.s2.pwm_trip || st_ff.s2.ilim_trip) begin
					cl_evt         = st_ff.s2.ilim_trip;
					nxt_st.hs      = 1'b0;
					nxt_st.off_cnt = OW'(MIN_OFF);
					nxt_st.gate    = buck_ctl_pkg::G_HS_FALL;
				end
			end
			buck_ctl_pkg::G_HS_FALL: begin
				if (st_ff.s2.hs_gate_low) begin
					nxt_st.dly  = DW'(DEAD - 1);
					nxt_st.gate = buck_ctl_pkg::G_LS_DLY;
				end
			end
			buck_ctl_pkg::G_LS_DLY: begin
				if (st_ff.dly != '0) begin
					nxt_st.dly = DW'(st_ff.dly - 1'b1);
				end else if (de_now
					&& st_ff.s2.switch_node_above_neg) begin
					nxt_st.gate = buck_ctl_pkg::G_IDLE;
				end else begin
					nxt_st.ls   = 1'b1;
					nxt_st.gate = buck_ctl_pkg::G_LS_ON;
				end
			end
			default: begin
				nxt_st.hs   = 1'b0;
				nxt_st.ls   = 1'b0;
				nxt_st.gate = buck_ctl_pkg::G_IDLE;
			end
			endcase

			cl_any = st_ff.cl_seen | cl_evt;
			if (tick) begin
				nxt_st.pend    = 1'b1;
				nxt_st.smp     = 1'b1;
				nxt_st.cl_seen = 1'b0;
				if (st_ff.gate == buck_ctl_pkg::G_HS_ON) begin
					nxt_st.hs      = 1'b0;
					nxt_st.off_cnt = OW'(MIN_OFF);
					nxt_st.gate    = buck_ctl_pkg::G_HS_FALL;
				end
				if (!cl_any) begin
					nxt_st.cl_cnt = '0;
				end else if (st_ff.cl_cnt != CW'(CL_COUNT - 1)) begin
					nxt_st.cl_cnt = CW'(st_ff.cl_cnt + 1'b1);
				end else if (st_ff.rmode != buck_ctl_pkg::RM_NONE) begin
					nxt_st.cl_cnt = '0;
					nxt_st.hs     = 1'b0;
					nxt_st.ls     = 1'b0;
					nxt_st.gate   = buck_ctl_pkg::G_IDLE;
					nxt_st.pend   = 1'b0;
					nxt_st.ss_dis = 1'b1;
					if (st_ff.rmode == buck_ctl_pkg::RM_LATCH) begin
						nxt_st.op = buck_ctl_pkg::OP_LATCHED;
					end else begin
						nxt_st.op      = buck_ctl_pkg::OP_HICCUP;
						nxt_st.rst_chg = 1'b1;
					end
				end
			end else begin
				nxt_st.cl_seen = cl_any;
			end
			if (!run_ok) begin
				nxt_st.op   = buck_ctl_pkg::OP_OFF;
				nxt_st.hs   = 1'b0;
				nxt_st.ls   = 1'b0;
				nxt_st.gate = buck_ctl_pkg::G_IDLE;
				nxt_st.ss_dis  = 1'b1;
				nxt_st.rst_chg = 1'b0;
			end
		end
		buck_ctl_pkg::OP_HICCUP: begin
			nxt_st.hs     = 1'b0;
			nxt_st.ls     = 1'b0;
			nxt_st.ss_dis = 1'b1;
			if (!run_ok) begin
				nxt_st.op      = buck_ctl_pkg::OP_OFF;
				nxt_st.rst_chg = 1'b0;
			end else if (st_ff.s2.restart_above_th) begin
				nxt_st.rst_chg = 1'b0;
				nxt_st.rst_dis = 1'b1;
				nxt_st.ss_dis  = 1'b0;
				nxt_st.op      = buck_ctl_pkg::OP_RUN;
			end
		end
		buck_ctl_pkg::OP_LATCHED: begin
			nxt_st.hs     = 1'b0;
			nxt_st.ls     = 1'b0;
			nxt_st.ss_dis = 1'b1;
			if (!st_ff.s2.line_uv_above_shdn) begin
				nxt_st.op = buck_ctl_pkg::OP_OFF;
			end
		end
		default: begin
			nxt_st.op = buck_ctl_pkg::OP_OFF;
			nxt_st.hs = 1'b0;
			nxt_st.ls = 1'b0;
		end
		endcase

		// register slave, write side
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (s_axi_awvalid && st_ff.awrdy) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wrdy) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wbit  = s_axi_wdata[buck_ctl_pkg::CTRL_RUN_BIT];
			nxt_st.wstb  = s_axi_wstrb[0];
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = reg_hit(st_ff.waddr) ? buck_ctl_pkg::RESP_OKAY
				: buck_ctl_pkg::RESP_SLVERR;
			if (st_ff.wstb && st_ff.waddr
				== AXI_AW'(buck_ctl_pkg::CTRL_OFFS)) begin
				nxt_st.run_en = st_ff.wbit;
			end
		end
		nxt_st.awrdy = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wrdy  = !nxt_st.w_got && !nxt_st.bvalid;

		// register slave, read side
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_ff.arrdy) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = reg_hit(s_axi_araddr) ? buck_ctl_pkg::RESP_OKAY
				: buck_ctl_pkg::RESP_SLVERR;
			nxt_st.rdata  = 32'h0000_0000;
			if (s_axi_araddr == AXI_AW'(buck_ctl_pkg::CTRL_OFFS)) begin
				nxt_st.rdata = 32'(st_ff.run_en);
			end else if (s_axi_araddr
				== AXI_AW'(buck_ctl_pkg::STATUS_OFFS)) begin
				nxt_st.rdata = 32'({st_ff.hs, st_ff.ls, st_ff.de,
					st_ff.cfg_done, st_ff.rmode, st_ff.op, st_ff.gate});
			end else if (s_axi_araddr
				== AXI_AW'(buck_ctl_pkg::CLCNT_OFFS)) begin
				nxt_st.rdata = 32'(st_ff.cl_cnt);
			end
		end
		nxt_st.arrdy = !nxt_st.rvalid;
	end

	// ====================================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff        <= '0;
			st_ff.op     <= buck_ctl_pkg::OP_OFF;
			st_ff.gate   <= buck_ctl_pkg::G_IDLE;
			st_ff.rmode  <= buck_ctl_pkg::RM_HICCUP;
			st_ff.ss_dis <= 1'b1;
			st_ff.de     <= 1'b1;
			st_ff.run_en <= buck_ctl_pkg::CTRL_RUN_RST;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// ====================================================================
	// outputs
	assign high_side_gate    = st_ff.hs;
	assign low_side_gate     = st_ff.ls;
	assign ss_discharge      = st_ff.ss_dis;
	assign ref_from_ss       = st_ff.ref_ss;
	assign restart_charge    = st_ff.rst_chg;
	assign restart_discharge = st_ff.rst_dis;
	assign sample_hold       = st_ff.smp;
	assign diode_emulation   = st_ff.de;
	assign s_axi_awready     = st_ff.awrdy;
	assign s_axi_wready      = st_ff.wrdy;
	assign s_axi_bresp       = st_ff.bresp;
	assign s_axi_bvalid      = st_ff.bvalid;
	assign s_axi_arready     = st_ff.arrdy;
	assign s_axi_rdata       = st_ff.rdata;
	assign s_axi_rresp       = st_ff.rresp;
	assign s_axi_rvalid      = st_ff.rvalid;

endmodule // buck_pwm_sequencer

// ---- verification/buck_pwm_sequencer_monitor.sv ----
module buck_pwm_sequencer_monitor #(
	parameter int MIN_OFF = 40
) (
	input wire logic aclk,                  // clock
	input wire logic aresetn,               // sync reset
	input wire logic bias_ok,               // bias good
	input wire logic line_uv_above_th,      // line good
	input wire logic ss_below_ref,          // soft-start low
	input wire logic switch_node_above_neg, // node above -5mV
	input wire logic high_side_gate,        // high gate
	input wire logic low_side_gate,         // low gate
	input wire logic ss_discharge,          // ss pull-down
	input wire logic restart_charge,        // restart source
	input wire logic diode_emulation        // emulation active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	int off_cnt;

	// ====================================================================
	// high side off-time, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn)
			off_cnt <= MIN_OFF;
		else if (high_side_gate)
			off_cnt <= 0;
		else if (off_cnt < MIN_OFF)
			off_cnt <= off_cnt + 1;
	end

	// ====================================================================
	// properties
	property p_no_overlap;
		!(high_side_gate && low_side_gate);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both gates on");
	property p_hs_rise;
		$rose(high_side_gate) |-> !$past(low_side_gate)
			&& !$past(low_side_gate, 4);
	endproperty
	a_hs_rise: assert property (p_hs_rise)
		else $error("high on too soon");
	property p_ls_rise;
		$rose(low_side_gate) |-> !$past(high_side_gate)
			&& !$past(high_side_gate, 4);
	endproperty
	a_ls_rise: assert property (p_ls_rise)
		else $error("low on too soon");
	property p_min_off;
		$rose(high_side_gate) |-> off_cnt >= MIN_OFF;
	endproperty
	a_min_off: assert property (p_min_off)
		else $error("off time short");
	property p_bias;
		(!bias_ok)[*6] |-> !high_side_gate && !low_side_gate;
	endproperty
	a_bias: assert property (p_bias)
		else $error("gates on without bias");
	property p_line;
		(!line_uv_above_th)[*6] |-> ss_discharge && !high_side_gate
			&& !low_side_gate;
	endproperty
	a_line: assert property (p_line)
		else $error("line standby broken");
	property p_de_force;
		ss_below_ref[*6] |-> diode_emulation;
	endproperty
	a_de_force: assert property (p_de_force)
		else $error("emulation not forced");
	property p_de_off;
		(diode_emulation && switch_node_above_neg)[*6] |-> !low_side_gate;
	endproperty
	a_de_off: assert property (p_de_off)
		else $error("low on with reverse current");
	property p_standby;
		restart_charge |-> ss_discharge && !high_side_gate
			&& !low_side_gate;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not quiet");
endmodule // buck_pwm_sequencer_monitor

bind buck_pwm_sequencer buck_pwm_sequencer_monitor #(
	.MIN_OFF(MIN_OFF)
) u_mon (
	.aclk, .aresetn, .bias_ok, .line_uv_above_th, .ss_below_ref,
	.switch_node_above_neg, .high_side_gate, .low_side_gate,
	.ss_discharge, .restart_charge, .diode_emulation
);

// ---- verification/power_switch_model.sv ----
module power_switch_model #(
	parameter int FALL = 3
) (
	input  wire logic aclk,        // clock
	input  wire logic hs_cmd,      // high gate command
	input  wire logic ls_cmd,      // low gate command
	input  wire logic light,       // inductor current reversed
	output logic      hs_gate_low, // high gate drained
	output logic      ls_gate_low, // low gate drained
	output logic      node_above   // node above -5mV
);
	timeunit 1ns;
	timeprecision 1ps;
	int hs_t = FALL;
	int ls_t = FALL;

	// ====================================================================
	// gate charge drains some cycles after release
	always @(posedge aclk) begin
		hs_t <= hs_cmd ? 0 : hs_t + int'(hs_t < FALL);
		ls_t <= ls_cmd ? 0 : ls_t + int'(ls_t < FALL);
	end
	assign hs_gate_low = hs_t >= FALL;
	assign ls_gate_low = ls_t >= FALL;
	// conducting high switch or reverse current lifts the node
	assign node_above = !hs_gate_low || light;
endmodule // power_switch_model

// ---- verification/test_buck_pwm_fault_and_gate_sequencer.sv ----
module test_buck_pwm_fault_and_gate_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TP = 100;
	localparam int CL = 4;
	localparam logic [1:0] OK = buck_ctl_pkg::RESP_OKAY;
	localparam logic [31:0] ST_LATCHED = 32'({3'h0, 1'h1,
		buck_ctl_pkg::RM_LATCH, buck_ctl_pkg::OP_LATCHED,
		buck_ctl_pkg::G_IDLE});
	logic aclk = 0, aresetn = 0, osc_tick = 0, pwm_trip = 0, ilim_trip = 0;
	logic ss_below_ref = 0, restart_above_th = 0, restart_grounded = 0;
	logic sample_over_limit = 0, line_uv_above_shdn = 1, line_uv_above_th = 1;
	logic bias_ok = 1, diode_emulation_select = 1, light = 0, pwm_en = 1;
	logic ilim_en = 0, hs_q = 0, ls_q = 0, switch_node_above_neg;
	logic ls_gate_low, hs_gate_low, high_side_gate, low_side_gate;
	logic ss_discharge, restart_charge, restart_discharge, ref_from_ss;
	logic sample_hold, diode_emulation, s_axi_awready, s_axi_wready;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int ph = 0, n_hr = 0, n_lr = 0, n_sh = 0, err_total = 0, n_tests = 0;

	buck_pwm_sequencer #(.CL_COUNT(CL)) u_buck_pwm_sequencer (
		.aclk, .aresetn, .clk_en(1'h1), .pwm_trip, .ilim_trip, .ss_below_ref,
		.switch_node_above_neg, .restart_above_th, .restart_grounded,
		.sample_over_limit, .line_uv_above_shdn, .line_uv_above_th, .bias_ok,
		.diode_emulation_select, .ls_gate_low, .hs_gate_low, .osc_tick,
		.high_side_gate, .low_side_gate, .ss_discharge, .ref_from_ss,
		.restart_charge, .restart_discharge, .sample_hold, .diode_emulation,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	power_switch_model u_power_switch_model (
		.aclk, .hs_cmd(high_side_gate), .ls_cmd(low_side_gate), .light,
		.hs_gate_low, .ls_gate_low, .node_above(switch_node_above_neg)
	);

	// ====================================================================
	// clock, oscillator phase, trips, edge counts
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		ph <= (ph == TP - 1) ? 0 : ph + 1;
		osc_tick <= ph < 4;
		pwm_trip <= pwm_en && ph >= 50 && ph < 54;
		ilim_trip <= ilim_en && ph >= 30 && ph < 34;
		hs_q <= high_side_gate;
		ls_q <= low_side_gate;
		if (high_side_gate && !hs_q)
			n_hr <= n_hr + 1;
		if (low_side_gate && !ls_q)
			n_lr <= n_lr + 1;
		if (sample_hold)
			n_sh <= n_sh + 1;
	end

	// ====================================================================
	// shared tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task at_ph(input int p);
		do @(posedge aclk); while (ph != p);
	endtask
	task rises(input int np, input int exp, input bit lo);
		int n0;
		n0 = lo ? n_lr : n_hr;
		repeat (np * TP) @(posedge aclk);
		chk("gate rises", (lo ? n_lr : n_hr) - n0, exp);
	endtask
	task rst(input logic ra, input logic rg);
		@(posedge aclk);
		aresetn <= 1'h0;
		restart_above_th <= ra;
		restart_grounded <= rg;
		repeat (19) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (TP) @(posedge aclk);
		restart_above_th <= 1'h0;
		restart_grounded <= 1'h0;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		repeat (64) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'h0;
		chk("bvalid", s_axi_bvalid, 1'h1);
		chk("bresp", s_axi_bresp, er);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		repeat (64) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'h0;
		chk("rvalid", s_axi_rvalid, 1'h1);
		chk("rdata", s_axi_rdata, ed);
		chk("rresp", s_axi_rresp, er);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ====================================================================
	// scenarios
	task t_regs;
		rd(4'h0, 32'h1, OK);
		wr(4'h0, 32'h0, OK);
		rd(4'h0, 32'h0, OK);
		wr(4'h0, 32'h1, OK);
		wr(4'hC, 32'h5, buck_ctl_pkg::RESP_SLVERR);
		rd(4'hC, 32'h0, buck_ctl_pkg::RESP_SLVERR);
		$display("done registers");
	endtask
	task t_switch;
		at_ph(TP / 2);
		rises(5, 5, 0);
		at_ph(40);
		chk("high on", high_side_gate, 1'h1);
		at_ph(70);
		chk("high off", high_side_gate, 1'h0);
		rises(2, 2, 1);
		pwm_en <= 1'h0;
		at_ph(80);
		rises(5, 5, 0);
		at_ph(20);
		chk("forced off", high_side_gate, 1'h0);
		at_ph(95);
		chk("long on", high_side_gate, 1'h1);
		pwm_en <= 1'h1;
		$display("done switching");
	endtask
	task t_de;
		diode_emulation_select <= 1'h0;
		light <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("emulation", diode_emulation, 1'h1);
		rises(2, 0, 1);
		light <= 1'h0;
		diode_emulation_select <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("continuous", diode_emulation, 1'h0);
		chk("ref low", ref_from_ss, 1'h0);
		ss_below_ref <= 1'h1;
		light <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("forced", diode_emulation, 1'h1);
		chk("ref high", ref_from_ss, 1'h1);
		rises(2, 0, 1);
		ss_below_ref <= 1'h0;
		light <= 1'h0;
		$display("done emulation");
	endtask
	task t_line;
		line_uv_above_th <= 1'h0;
		repeat (10) @(posedge aclk);
		chk("ss held", ss_discharge, 1'h1);
		rises(2, 0, 0);
		line_uv_above_th <= 1'h1;
		bias_ok <= 1'h0;
		rises(2, 0, 0);
		bias_ok <= 1'h1;
		at_ph(50);
		rises(2, 2, 0);
		$display("done line");
	endtask
	task t_hiccup;
		at_ph(50);
		ilim_en <= 1'h1;
		repeat ((CL - 1) * TP) @(posedge aclk);
		ilim_en <= 1'h0;
		repeat (TP) @(posedge aclk);
		ilim_en <= 1'h1;
		repeat (CL * TP) @(posedge aclk);
		chk("no standby", restart_charge, 1'h0);
		repeat (TP) @(posedge aclk);
		chk("standby", restart_charge, 1'h1);
		chk("ss low", ss_discharge, 1'h1);
		ilim_en <= 1'h0;
		rises(2, 0, 0);
		restart_above_th <= 1'h1;
		repeat (10) @(posedge aclk);
		chk("node drain", restart_discharge, 1'h1);
		chk("charge off", restart_charge, 1'h0);
		restart_above_th <= 1'h0;
		at_ph(50);
		rises(3, 3, 0);
		$display("done hiccup");
	endtask
	task t_latch;
		rst(1'h0, 1'h1);
		at_ph(50);
		ilim_en <= 1'h1;
		repeat ((CL + 2) * TP) @(posedge aclk);
		ilim_en <= 1'h0;
		rises(3, 0, 0);
		rd(4'h4, ST_LATCHED, OK);
		line_uv_above_shdn <= 1'h0;
		line_uv_above_th <= 1'h0;
		repeat (20) @(posedge aclk);
		line_uv_above_shdn <= 1'h1;
		line_uv_above_th <= 1'h1;
		at_ph(50);
		rises(2, 2, 0);
		$display("done latch");
	endtask
	task t_skip;
		int s0;
		rst(1'h1, 1'h0);
		at_ph(50);
		ilim_en <= 1'h1;
		rises(CL + 4, CL + 4, 0);
		chk("no hiccup", restart_charge, 1'h0);
		rd(4'h8, 32'(CL - 1), OK);
		ilim_en <= 1'h0;
		sample_over_limit <= 1'h1;
		s0 = n_sh;
		rises(3, 0, 0);
		chk("samples", n_sh - s0, 32'h3);
		sample_over_limit <= 1'h0;
		at_ph(50);
		rises(2, 2, 0);
		$display("done skip");
	endtask

	initial begin
		rst(1'h0, 1'h0);
		t_regs();
		t_switch();
		t_de();
		t_line();
		t_hiccup();
		t_latch();
		t_skip();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		give_verdict();
	end
endmodule // test_buck_pwm_fault_and_gate_sequencer
